// ### design/biod_defines.svh
// constants for the branch, increment and OR decode block
`ifndef BIOD_DEFINES_SVH
`define BIOD_DEFINES_SVH

// =====================================================================
// instruction word fields
`define BIOD_WORD_W        14
`define BIOD_PC_W          13
`define BIOD_BRANCH_OP     3'h5
`define BIOD_BRANCH_OP_HI  13
`define BIOD_BRANCH_OP_LO  11
`define BIOD_BRANCH_K_HI   10
`define BIOD_REG_OP_HI     13
`define BIOD_REG_OP_LO     8
`define BIOD_OP_INC        6'h0A
`define BIOD_OP_INCSKIP    6'h0F
`define BIOD_OP_OR         6'h04
`define BIOD_DEST_BIT      7
`define BIOD_ADDR_HI       6
`define BIOD_LATCH_HI      4
`define BIOD_LATCH_LO      3

// =====================================================================
// reset values
`define BIOD_PC_RESET      13'h0000
`define BIOD_ACC_RESET     8'h00

`endif

// ### design/biod_pkg.sv
// types shared by the branch, increment and OR decode block
package biod_pkg;

    typedef enum logic [1:0] {
        BIOD_RUN,
        BIOD_FLUSH
    } biod_state_t;

    // write port into the data register memory
    typedef struct packed {
        logic       en;
        logic [6:0] addr;
        logic [7:0] data;
    } biod_wr_t;

    // zero flag update toward the status register
    typedef struct packed {
        logic       en;
        logic       value;
    } biod_zero_t;

endpackage

// ### design/biod_regfile.sv
// small data register memory with registered read data
`timescale 1ns/1ps
`include "biod_defines.svh"

module biod_regfile
    import biod_pkg::*;
#(
    parameter int DEPTH = 128
) (
    // clock
    input  wire logic       ref_clk,
    // read port
    input  wire logic [6:0] rdAddr,
    output logic      [7:0] rdData,
    // write port
    input  wire biod_wr_t   wr
);

    logic [7:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wr.en) begin
            mem[wr.addr] <= wr.data;
        end
        // write-through keeps back-to-back dependent words correct
        if (wr.en && wr.addr == rdAddr) begin
            rdData <= wr.data;
        end else begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

// ### design/biod_core.sv
// decode and execute of branch, increment, increment-skip and OR words
`timescale 1ns/1ps
`include "biod_defines.svh"

// Contract
// - branch copies 11-bit immediate into program counter bits 10..0.
// - branch takes counter bits 12..11 from upper latch bits 4..3.
// - branch takes two cycles, one word, leaves all flags unchanged.
// - target bit 0 writes accumulator, 1 writes addressed data register.
// - increment adds one to register, routes sum, updates zero flag.
// - increment-skip adds one, stores sum, discards fetched word if zero, no flags.
// - a skip executes a no-operation instead, making two cycles.
// - OR combines accumulator and register, routes result, updates zero flag.

module biod_core
    import biod_pkg::*;
#(
    parameter int ADDR_W = 7
) (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_b,
    // instruction stream
    input  wire logic                    instrValid,
    input  wire logic [`BIOD_WORD_W-1:0] instrWord,
    input  wire logic [7:0]              upper_branch_latch,
    // data register side port
    input  wire biod_wr_t                extWr,
    // state shown outward
    output logic [`BIOD_PC_W-1:0]        program_counter,
    output logic [7:0]                   accumulator,
    output biod_zero_t                   zeroUpd,
    output logic                         discard,
    output logic                         busy
);

    // =================================================================
    // decode helpers
    function automatic logic is_branch(input logic [`BIOD_WORD_W-1:0] w);
        return w[`BIOD_BRANCH_OP_HI:`BIOD_BRANCH_OP_LO] == `BIOD_BRANCH_OP;
    endfunction

    function automatic logic is_reg_op(input logic [`BIOD_WORD_W-1:0] w,
                                       input logic [5:0]              op);
        return w[`BIOD_REG_OP_HI:`BIOD_REG_OP_LO] == op;
    endfunction

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    // =================================================================
    // state
    typedef struct packed {
        biod_state_t                  state;
        logic [`BIOD_PC_W-1:0]        pc;
        logic [7:0]                   acc;
        logic                         zeroEn;
        logic                         zeroVal;
        logic                         discard;
        logic [`BIOD_WORD_W-1:0]      held;
    } biod_core_t;

    biod_core_t st;
    biod_core_t next_st;

    // operand fetch phase: word latched in RUN, executed once register read back
    logic [ADDR_W-1:0] rdAddr;
    logic [7:0]        rdData;
    biod_wr_t          coreWr;
    biod_wr_t          memWr;
    logic              execNow;
    logic [7:0]        result;
    logic [7:0]        incSum;
    logic              toReg;

    assign rdAddr = instrWord[`BIOD_ADDR_HI:0];
    assign memWr  = coreWr.en ? coreWr : extWr;
    assign incSum = rdData + 8'h01;
    assign toReg  = st.held[`BIOD_DEST_BIT];

    // =================================================================
    // decode of the incoming word and of the held word
    logic inBranch;
    logic inInc;
    logic inSkip;
    logic inOr;
    logic inRegOp;
    logic heldInc;
    logic heldSkip;
    logic heldOr;
    logic heldAny;

    assign inBranch = is_branch(instrWord);
    assign inInc    = is_reg_op(instrWord, `BIOD_OP_INC);
    assign inSkip   = is_reg_op(instrWord, `BIOD_OP_INCSKIP);
    assign inOr     = is_reg_op(instrWord, `BIOD_OP_OR);
    assign inRegOp  = inInc || inSkip || inOr;

    // held is cleared to zero when idle, and no register word decodes as zero
    assign heldInc  = is_reg_op(st.held, `BIOD_OP_INC);
    assign heldSkip = is_reg_op(st.held, `BIOD_OP_INCSKIP);
    assign heldOr   = is_reg_op(st.held, `BIOD_OP_OR);
    assign heldAny  = heldInc || heldSkip || heldOr;

    biod_regfile #(
        .DEPTH (1 << ADDR_W)
    ) biod_regfile_i (
        .ref_clk (ref_clk),
        .rdAddr  (rdAddr),
        .rdData  (rdData),
        .wr      (memWr)
    );

    // =================================================================
    // next state
    always_comb begin
        next_st         = st;
        next_st.zeroEn  = 1'b0;
        next_st.discard = 1'b0;
        next_st.held    = '0;
        coreWr          = '0;
        result          = 8'h00;
        execNow         = 1'b0;
        case (st.state)
            BIOD_RUN: begin
                if (heldAny) begin
                    execNow    = 1'b1;
                    next_st.pc = st.pc + `BIOD_PC_W'(1);
                    if (heldInc) begin
                        result = incSum;
                        next_st.zeroEn  = 1'b1;
                        next_st.zeroVal = is_zero(result);
                    end else if (heldSkip) begin
                        result = incSum;
                        if (is_zero(result)) begin
                            // counter steps over the dropped word here, so the
                            // flush cycle never depends on what the bus shows
                            next_st.pc      = st.pc + `BIOD_PC_W'(2);
                            next_st.discard = 1'b1;
                            next_st.state   = BIOD_FLUSH;
                        end
                    end else begin
                        result = st.acc | rdData;
                        next_st.zeroEn  = 1'b1;
                        next_st.zeroVal = is_zero(result);
                    end
                    // target bit picks accumulator or register
                    if (toReg) begin
                        coreWr.en   = 1'b1;
                        coreWr.addr = st.held[`BIOD_ADDR_HI:0];
                        coreWr.data = result;
                    end else begin
                        next_st.acc = result;
                    end
                end
                if (instrValid && next_st.state == BIOD_RUN) begin
                    if (inBranch) begin
                        // branch leaves flags alone; the flush cycle is its second
                        next_st.pc = {upper_branch_latch[`BIOD_LATCH_HI:`BIOD_LATCH_LO],
                                      instrWord[`BIOD_BRANCH_K_HI:0]};
                        next_st.discard = 1'b1;
                        next_st.state   = BIOD_FLUSH;
                    end else if (inRegOp) begin
                        next_st.held = instrWord;
                    end else begin
                        // words outside this block just advance the counter
                        next_st.pc = next_st.pc + `BIOD_PC_W'(1);
                    end
                end
            end
            BIOD_FLUSH: begin
                // no-operation slot in place of the prefetched word
                next_st.state = BIOD_RUN;
            end
            default: begin
                next_st.state = BIOD_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st.state   <= BIOD_RUN;
            st.pc      <= `BIOD_PC_RESET;
            st.acc     <= `BIOD_ACC_RESET;
            st.zeroEn  <= 1'b0;
            st.zeroVal <= 1'b0;
            st.discard <= 1'b0;
            st.held    <= '0;
        end else begin
            st <= next_st;
        end
    end

    // =================================================================
    // outputs
    assign program_counter = st.pc;
    assign accumulator     = st.acc;
    assign zeroUpd.en      = st.zeroEn;
    assign zeroUpd.value   = st.zeroVal;
    assign discard         = st.discard;
    assign busy            = (st.state == BIOD_FLUSH) || execNow;

endmodule

// ### verif/biod_core_props.sv
// concurrent checks on the decode block ports
`timescale 1ns/1ps
`include "biod_defines.svh"
module biod_core_props
    import biod_pkg::*;
(
    // clock and reset
    input wire logic                    ref_clk,
    input wire logic                    rst_b,
    // inputs watched
    input wire logic                    instrValid,
    input wire logic [`BIOD_WORD_W-1:0] instrWord,
    input wire logic [7:0]              upper_branch_latch,
    input wire biod_wr_t                extWr,
    // outputs watched
    input wire logic [`BIOD_PC_W-1:0]   program_counter,
    input wire logic [7:0]              accumulator,
    input wire biod_zero_t              zeroUpd,
    input wire logic                    discard,
    input wire logic                    busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // a word shown during the flush cycle is not taken
    wire logic isBr = instrValid && !discard && instrWord[13:11] == 3'h5;
    sequence s_reg(logic [5:0] o, logic dd);
        instrValid && !discard && instrWord[13:8] == o && instrWord[7] == dd;
    endsequence
    sequence s_flush;
        (discard && busy) ##1 !discard;
    endsequence
    property p_br_low;
        isBr |=> program_counter[10:0] == $past(instrWord[10:0]);
    endproperty
    a_br_low: assert property (p_br_low) else $error("branch low bits wrong");
    property p_br_high;
        isBr |=> program_counter[12:11] == $past(upper_branch_latch[4:3]);
    endproperty
    a_br_high: assert property (p_br_high) else $error("branch high bits wrong");
    property p_br_flush;
        isBr |=> s_flush;
    endproperty
    a_br_flush: assert property (p_br_flush) else $error("branch not two cycles");
    property p_br_flags;
        isBr |-> ##2 !zeroUpd.en;
    endproperty
    a_br_flags: assert property (p_br_flags) else $error("branch touched flag");
    property p_inc_z;
        s_reg(6'h0A, 1'b0) |-> ##2 zeroUpd.en && zeroUpd.value == (accumulator == 8'h00);
    endproperty
    a_inc_z: assert property (p_inc_z) else $error("increment zero flag wrong");
    property p_skip_noz;
        (instrValid && !discard && instrWord[13:8] == 6'h0F) |-> ##2 !zeroUpd.en;
    endproperty
    a_skip_noz: assert property (p_skip_noz) else $error("skip touched flag");
    property p_skip_disc;
        s_reg(6'h0F, 1'b0) |-> ##2 discard == (accumulator == 8'h00);
    endproperty
    a_skip_disc: assert property (p_skip_disc) else $error("skip discard wrong");
    property p_or_z;
        s_reg(6'h04, 1'b0) |-> ##2 zeroUpd.en && zeroUpd.value == (accumulator == 8'h00);
    endproperty
    a_or_z: assert property (p_or_z) else $error("or zero flag wrong");
    property p_keep_acc;
        s_reg(6'h0A, 1'b1) |-> ##2 $stable(accumulator);
    endproperty
    a_keep_acc: assert property (p_keep_acc) else $error("register target hit acc");
    property p_one_cyc;
        s_reg(6'h04, 1'b1) |-> ##2 zeroUpd.en && !discard;
    endproperty
    a_one_cyc: assert property (p_one_cyc) else $error("or not single cycle");
endmodule
bind biod_core biod_core_props biod_core_props_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .instrValid(instrValid), .instrWord(instrWord), .upper_branch_latch(upper_branch_latch),
    .extWr(extWr), .program_counter(program_counter), .accumulator(accumulator),
    .zeroUpd(zeroUpd), .discard(discard), .busy(busy));

// ### verif/biod_core_tb_top.sv
// self-checking bench for the decode block
`timescale 1ns/1ps
module biod_core_tb_top
    import biod_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        instrValid = 1'b0;
    logic [13:0] instrWord = 14'h0000;
    logic [7:0]  latch = 8'h00;
    biod_wr_t    extWr = '0;
    logic [12:0] pc;
    logic [7:0]  acc;
    biod_zero_t  zeroUpd;
    logic        discard;
    logic        busy;
    int          err_count = 0;
    int          checks = 0;
    always #20 ref_clk = ~ref_clk;
    biod_core biod_core_i (.ref_clk(ref_clk), .rst_b(rst_b), .instrValid(instrValid),
        .instrWord(instrWord), .upper_branch_latch(latch), .extWr(extWr),
        .program_counter(pc), .accumulator(acc), .zeroUpd(zeroUpd), .discard(discard),
        .busy(busy));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (err_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [13:0] w(logic [5:0] o, logic d, logic [6:0] f);
        return {o, d, f};
    endfunction
    // preload through the side port, the only way to load a chosen value into the data registers
    task automatic ld(input logic [6:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        extWr <= '{en: 1'b1, addr: a, data: v};
        @(posedge ref_clk);
        extWr <= '0;
    endtask
    // one word, then idle long enough to cover any flush cycle
    task automatic op(input logic [13:0] iw, input logic [12:0] pcE, input logic [7:0] accE,
                      input logic discE);
        logic d;
        d = 1'b0;
        @(posedge ref_clk);
        instrValid <= 1'b1;
        instrWord <= iw;
        repeat (4) begin
            @(posedge ref_clk);
            instrValid <= 1'b0;
            #1 d = d | discard;
        end
        chk(pc, pcE);
        chk(acc, accE);
        chk(d, discE);
    endtask
    task automatic t_branch;
        @(posedge ref_clk);
        latch <= 8'h18;
        op({3'h5, 11'h5A5}, 13'h1DA5, 8'h00, 1'b1);
        latch <= 8'h08;
        op({3'h5, 11'h7FF}, 13'h0FFF, 8'h00, 1'b1);
        latch <= 8'hE7;
        op({3'h5, 11'h001}, 13'h0001, 8'h00, 1'b1);
    endtask
    task automatic t_inc;
        ld(7'h05, 8'hFF);
        op(w(6'h0A, 1'b0, 7'h05), 13'h0002, 8'h00, 1'b0);
        op(w(6'h0A, 1'b1, 7'h05), 13'h0003, 8'h00, 1'b0);
        op(w(6'h0A, 1'b0, 7'h05), 13'h0004, 8'h01, 1'b0);
    endtask
    task automatic t_or;
        ld(7'h06, 8'h80);
        op(w(6'h04, 1'b0, 7'h06), 13'h0005, 8'h81, 1'b0);
        ld(7'h07, 8'h00);
        ld(7'h08, 8'hFF);
        op(w(6'h0A, 1'b0, 7'h08), 13'h0006, 8'h00, 1'b0);
        op(w(6'h04, 1'b0, 7'h07), 13'h0007, 8'h00, 1'b0);
        op(w(6'h04, 1'b1, 7'h07), 13'h0008, 8'h00, 1'b0);
        op(w(6'h0A, 1'b0, 7'h07), 13'h0009, 8'h01, 1'b0);
    endtask
    task automatic t_skip;
        ld(7'h09, 8'hFF);
        op(w(6'h0F, 1'b0, 7'h09), 13'h000B, 8'h00, 1'b1);
        op(w(6'h0F, 1'b1, 7'h09), 13'h000D, 8'h00, 1'b1);
        op(w(6'h0F, 1'b0, 7'h09), 13'h000E, 8'h01, 1'b0);
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_branch();
        t_inc();
        t_or();
        t_skip();
        test_done();
    end
endmodule
